/* logic/kms_scanner.sv */
module kms_scanner #(
  parameter int unsigned DEB_STEP = kms_pkg::DEB_STEP_CYC
) (
  // Clock, reset and clock enable.
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Register port behind the serial interface.
  input wire kms_pkg::kms_reg_req_t reg_req,
  output logic [15:0] reg_rdata,
  // Keypad matrix.
  output logic [3:0] row_drive,
  input wire logic [3:0] col_in,
  // Host interrupt, active low.
  output logic key_event_irq_n
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Cycles for a step count: a selector of zero still gives one step.
  function automatic logic [31:0] step_cycles(logic [3:0] sel,
                                              int unsigned step);
    step_cycles = ({28'h0000000, sel} + 32'h00000001) * 32'(step);
  endfunction

  // Key bit position for a row and column.
  function automatic logic [3:0] key_pos(logic [1:0] row, logic [1:0] col);
    key_pos = {row, col};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Column lines come from outside the clock domain.

  logic [3:0] col_clean;

  kms_col_sampler u_sampler (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .col_raw(col_in),
    .col_clean(col_clean)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register file.

  logic [15:0] cfg;
  logic [15:0] mask;
  logic [15:0] next_cfg;
  logic [15:0] next_mask;
  logic [15:0] next_rdata;
  logic read_seen;
  logic next_read_seen;
  logic [15:0] result;
  logic [15:0] next_result;
  logic irq_set;

  // Writes steer the scanner; reads return one cycle later.
  always_comb begin
    next_cfg = cfg;
    next_mask = mask;
    next_rdata = 16'h0000;
    if (reg_req.wr) begin
      case (reg_req.addr)
        kms_pkg::REG_CONFIG: next_cfg = reg_req.wdata;
        kms_pkg::REG_MASK: next_mask = reg_req.wdata;
        default: ;
      endcase
    end
    if (reg_req.rd) begin
      case (reg_req.addr)
        kms_pkg::REG_CONFIG: next_rdata = cfg;
        kms_pkg::REG_MASK: next_rdata = mask;
        kms_pkg::REG_RESULT: next_rdata = result;
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  // Reading the result arms the interrupt release; a fresh report clears
  // the armed state and wins over a read in the same cycle.
  always_comb begin
    next_read_seen = read_seen;
    if (reg_req.rd && reg_req.addr == kms_pkg::REG_RESULT) begin
      next_read_seen = 1'b1;
    end
    if (irq_set) begin
      next_read_seen = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg <= kms_pkg::CONFIG_RESET;
      mask <= kms_pkg::MASK_RESET;
      reg_rdata <= 16'h0000;
      read_seen <= 1'b0;
    end else if (ce) begin
      cfg <= next_cfg;
      mask <= next_mask;
      reg_rdata <= next_rdata;
      read_seen <= next_read_seen;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Scan engine.

  kms_pkg::kms_state_t state;
  kms_pkg::kms_state_t next_state;
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic [1:0] row;
  logic [1:0] next_row;
  logic [15:0] acc;
  logic [15:0] next_acc;
  logic confirm;
  logic next_confirm;
  logic [3:0] next_row_drive;
  logic next_irq_n;
  logic [31:0] scan_gap;
  logic [31:0] deb_time;
  logic [15:0] acc_now;
  logic [15:0] unmasked;

  assign scan_gap = step_cycles(cfg[kms_pkg::CFG_SCAN_LSB +: 4],
                                kms_pkg::SCAN_STEP_CYC);
  assign deb_time = step_cycles(cfg[kms_pkg::CFG_DEB_LSB +: 4],
                                DEB_STEP);

  // The whole matrix is walked one row at a time. A high column while a
  // row is driven marks that key, so a column tied high marks all four.
  always_comb begin
    acc_now = acc;
    for (int c = 0; c < 4; c++) begin
      acc_now[key_pos(row, 2'(c))] = col_clean[c];
    end
  end

  assign unmasked = acc_now & ~mask;

  // Periodic scan, then a second scan after the de-bounce time; only a
  // press still present on the second scan is reported. Polling keeps
  // the rows quiet between scans at the cost of up to one interval of
  // detection latency.
  always_comb begin
    next_state = state;
    next_timer = timer;
    next_row = row;
    next_acc = acc;
    next_confirm = confirm;
    next_row_drive = 4'h0;
    next_result = result;
    next_irq_n = key_event_irq_n;
    irq_set = 1'b0;
    case (state)
      kms_pkg::KMS_WAIT: begin
        if (timer + 32'h00000001 >= scan_gap) begin
          next_timer = 32'h00000000;
          next_row = 2'h0;
          next_acc = 16'h0000;
          next_row_drive = 4'h1;
          next_state = kms_pkg::KMS_SCAN;
        end else begin
          next_timer = timer + 32'h00000001;
        end
      end
      kms_pkg::KMS_SCAN: begin
        next_row_drive = row_drive;
        if (timer + 32'h00000001 < 32'(kms_pkg::ROW_SETTLE_CYC)) begin
          next_timer = timer + 32'h00000001;
        end else begin
          next_timer = 32'h00000000;
          next_acc = acc_now;
          if (row != 2'h3) begin
            next_row = row + 2'h1;
            next_row_drive = row_drive << 1;
          end else begin
            next_row_drive = 4'h0;
            next_state = kms_pkg::KMS_WAIT;
            if (!confirm) begin
              if (unmasked != 16'h0000) begin
                next_confirm = 1'b1;
                next_state = kms_pkg::KMS_DEBOUNCE;
              end else if (read_seen) begin
                next_irq_n = 1'b1;
              end
            end else begin
              next_confirm = 1'b0;
              if (unmasked != 16'h0000) begin
                next_result = unmasked;
                next_irq_n = 1'b0;
                irq_set = 1'b1;
              end
            end
          end
        end
      end
      kms_pkg::KMS_DEBOUNCE: begin
        if (timer + 32'h00000001 >= deb_time) begin
          next_timer = 32'h00000000;
          next_row = 2'h0;
          next_acc = 16'h0000;
          next_row_drive = 4'h1;
          next_state = kms_pkg::KMS_SCAN;
        end else begin
          next_timer = timer + 32'h00000001;
        end
      end
      default: begin
        next_state = kms_pkg::KMS_WAIT;
        next_timer = 32'h00000000;
        next_confirm = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= kms_pkg::KMS_WAIT;
      timer <= 32'h00000000;
      row <= 2'h0;
      acc <= 16'h0000;
      confirm <= 1'b0;
      row_drive <= 4'h0;
      result <= kms_pkg::RESULT_RESET;
      key_event_irq_n <= 1'b1;
    end else if (ce) begin
      state <= next_state;
      timer <= next_timer;
      row <= next_row;
      acc <= next_acc;
      confirm <= next_confirm;
      row_drive <= next_row_drive;
      result <= next_result;
      key_event_irq_n <= next_irq_n;
    end
  end

endmodule

/* logic/kms_pkg.sv */
package kms_pkg;

  // Clock rate of sys_clk.
  localparam int unsigned CLK_HZ = 50_000_000;

  // Register indices on the plain register port.
  localparam logic [1:0] REG_CONFIG = 2'h0;
  localparam logic [1:0] REG_MASK = 2'h1;
  localparam logic [1:0] REG_RESULT = 2'h2;

  // Field positions inside the configuration register.
  localparam int unsigned CFG_SCAN_LSB = 0;
  localparam int unsigned CFG_DEB_LSB = 4;
  localparam int unsigned CFG_SEL_W = 4;

  // Reset values.
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // Matrix size.
  localparam int unsigned ROWS = 4;
  localparam int unsigned COLS = 4;
  localparam int unsigned KEYS = ROWS * COLS;

  // Timing: one scan-interval step and one de-bounce step.
  localparam int unsigned SCAN_STEP_US = 10;
  localparam int unsigned SCAN_STEP_CYC = SCAN_STEP_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DEB_STEP_US = 1000;
  localparam int unsigned DEB_STEP_CYC = DEB_STEP_US * (CLK_HZ / 1_000_000);

  // Settle time after a row is driven, covering the three-stage sampler.
  localparam int unsigned ROW_SETTLE_NS = 160;
  localparam int unsigned ROW_SETTLE_CYC =
    (ROW_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // Request on the register port.
  typedef struct packed {
    logic [1:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } kms_reg_req_t;

  // Scanner states.
  typedef enum logic [1:0] {
    KMS_WAIT,
    KMS_SCAN,
    KMS_DEBOUNCE
  } kms_state_t;

endpackage

/* logic/kms_col_sampler.sv */
// Three-stage sampler for the column lines; the output changes only once
// the second and third stages agree, so a single metastable settle or a
// one-cycle glitch never reaches the scanner.
module kms_col_sampler (
  // Clock, reset and clock enable.
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Raw column lines and their filtered image.
  input wire logic [3:0] col_raw,
  output logic [3:0] col_clean
);

  logic [3:0] stage1;
  logic [3:0] stage2;
  logic [3:0] stage3;
  logic [3:0] next_clean;

  ////////////////////////////////////////////////////////////////////////
  // Accept a bit only where the two later stages agree.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      next_clean[i] = (stage2[i] == stage3[i]) ? stage3[i] : col_clean[i];
    end
  end

  // The first stage feeds the second stage and nothing else.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage1 <= 4'h0;
      stage2 <= 4'h0;
      stage3 <= 4'h0;
      col_clean <= 4'h0;
    end else if (ce) begin
      stage1 <= col_raw;
      stage2 <= stage1;
      stage3 <= stage2;
      col_clean <= next_clean;
    end
  end

endmodule

/* tb/kms_scanner_sva.sv */
module kms_scanner_sva #(
  parameter int unsigned DEB_STEP = 20
) (
  // Clock, reset and enable.
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Register port, keypad and interrupt.
  input wire kms_pkg::kms_reg_req_t reg_req,
  input wire logic [15:0] reg_rdata,
  input wire logic [3:0] row_drive,
  input wire logic [3:0] col_in,
  input wire logic key_event_irq_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic seen;
  ////////////////////////////////////////////////////////////////////////
  // Remembers a result read made while the interrupt is low.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      seen <= 1'b0;
    end else if (key_event_irq_n) begin
      seen <= 1'b0;
    end else if (ce && reg_req.rd && reg_req.addr == kms_pkg::REG_RESULT) begin
      seen <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  AST_ROW_ONEHOT: assert property ($onehot0(row_drive))
    else $error("row drive not one-hot");
  AST_RDATA_IDLE: assert property (!$past(reg_req.rd) |->
    reg_rdata == 16'h0000) else $error("read data outside its cycle");
  AST_ROW0_HOLD: assert property ($rose(row_drive[0]) |->
    row_drive == 4'h1 [*8] ##1 row_drive == 4'h2) else $error("row 0 timing");
  AST_ROW2_HOLD: assert property ($rose(row_drive[2]) |->
    row_drive == 4'h4 [*8] ##1 row_drive == 4'h8) else $error("row 2 timing");
  AST_SCAN_END: assert property ($fell(row_drive[3]) |->
    row_drive == 4'h0 [*8]) else $error("scan restarted too soon");
  AST_IRQ_FALL: assert property ($fell(key_event_irq_n) |->
    $past(row_drive[3]) || $past(row_drive[3], 2))
    else $error("interrupt fell away from a scan end");
  AST_IRQ_RISE: assert property ($rose(key_event_irq_n) |->
    $past(row_drive[3]) || $past(row_drive[3], 2))
    else $error("interrupt rose away from a scan end");
  AST_IRQ_READ: assert property ($rose(key_event_irq_n) |->
    $past(seen)) else $error("interrupt released without a read");
endmodule

bind kms_scanner kms_scanner_sva #(.DEB_STEP(DEB_STEP)) chk_u (
  .sys_clk(sys_clk), .rst(rst), .ce(ce), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .row_drive(row_drive), .col_in(col_in),
  .key_event_irq_n(key_event_irq_n));

/* tb/kms_keypad_model.sv */
module kms_keypad_model (
  // Rows from the scanner, columns back to it.
  input wire logic [3:0] row_drive,
  output logic [3:0] col_in,
  // Held keys and columns strapped high.
  input wire logic [15:0] keys,
  input wire logic [3:0] tie_col
);
  timeunit 1ns;
  timeprecision 1ps;
  // Passive switches; an unconnected column falls to its pull-down level.
  always_comb begin
    col_in = tie_col;
    for (int r = 0; r < 4; r++) begin
      for (int c = 0; c < 4; c++) begin
        if (row_drive[r] && keys[4*r+c]) col_in[c] = 1'b1;
      end
    end
  end
endmodule

/* tb/tb_keypad_matrix_scanner.sv */
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  bad_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_keypad_matrix_scanner;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  kms_pkg::kms_reg_req_t req = '0;
  logic [15:0] rdata;
  logic [3:0] rows;
  logic [3:0] cols;
  logic [3:0] tie = 4'h0;
  logic [15:0] keys = 16'h0000;
  logic irq_n;
  int bad_count = 0;
  int cmp_count = 0;
  kms_scanner #(.DEB_STEP(20)) dut_u (.sys_clk(sys_clk), .rst(rst), .ce(ce),
    .reg_req(req), .reg_rdata(rdata), .row_drive(rows), .col_in(cols),
    .key_event_irq_n(irq_n));
  kms_keypad_model pad_u (.row_drive(rows), .col_in(cols), .keys(keys),
    .tie_col(tie));
  // Free-running 50 MHz clock.
  initial forever #10 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////
  // Register cycles; read data is taken in the one cycle it stands.
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask
  task automatic chk_rd(input logic [1:0] a, input logic [15:0] e,
    input string n);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1 `CHK(n, e, rdata)
  endtask
  // Bounded wait; a scan interval is at most 1000 cycles here.
  task automatic wait_irq(input logic lvl, input string n);
    int i;
    i = 0;
    while (irq_n !== lvl && i < 4000) begin
      @(negedge sys_clk);
      i++;
    end
    `CHK(n, lvl, irq_n)
  endtask
  // Hold keys until reported, read, check the read alone keeps it low.
  task automatic press(input logic [15:0] k, input logic [3:0] t,
    input logic [15:0] e, input string n);
    @(posedge sys_clk);
    keys <= k;
    tie <= t;
    wait_irq(1'b0, n);
    chk_rd(kms_pkg::REG_RESULT, e, n);
    `CHK(n, 1'b0, irq_n)
    @(posedge sys_clk);
    keys <= 16'h0000;
    tie <= 4'h0;
    wait_irq(1'b1, n);
    $display("test %s done", n);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    chk_rd(kms_pkg::REG_CONFIG, kms_pkg::CONFIG_RESET, "cfg");
    chk_rd(kms_pkg::REG_MASK, kms_pkg::MASK_RESET, "mask");
    wr(kms_pkg::REG_RESULT, 16'hffff);
    chk_rd(kms_pkg::REG_RESULT, 16'h0000, "res ro");
    wr(2'h3, 16'hffff);
    chk_rd(2'h3, 16'h0000, "unmapped");
    $display("test regs done");
  endtask
  task automatic t_mask;
    wr(kms_pkg::REG_MASK, 16'h0020);
    @(posedge sys_clk);
    keys <= 16'h0020;
    repeat (1200) @(negedge sys_clk);
    `CHK("masked", 1'b1, irq_n)
    press(16'h0028, 4'h0, 16'h0008, "mask");
    wr(kms_pkg::REG_MASK, 16'h0000);
  endtask
  task automatic t_cfg;
    wr(kms_pkg::REG_CONFIG, 16'h0011);
    chk_rd(kms_pkg::REG_CONFIG, 16'h0011, "cfg wr");
    press(16'h8000, 4'h0, 16'h8000, "slow");
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs;
    press(16'h0200, 4'h0, 16'h0200, "one key");
    press(16'h8021, 4'h0, 16'h8021, "multi");
    press(16'h0000, 4'h1, 16'h1111, "tie col");
    t_mask;
    t_cfg;
    wrap_up;
  end
  // Tests need about 8k cycles; 50k leaves ample margin.
  initial begin
    #1_000_000;
    bad_count++;
    wrap_up;
  end
endmodule
